// file: rtl/timer16_pkg.sv
/*
 * Constants shared by the 16-bit timer/counter and its clock edge detector:
 * APB register offsets, control field positions, reset values, encodings.
 * Assumes a 32-bit APB with byte addresses and one register per aligned word.
 */
package timer16_pkg;

    // ------------------------------------------------------------------
    // Bus geometry
    // ------------------------------------------------------------------
    localparam int         ADDR_W = 8;
    localparam int         DATA_W = 32;

    // ------------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] OFS_TIMER_CONTROL   = 8'h00;
    localparam logic [7:0] OFS_COUNT_LOW_BYTE  = 8'h04;
    localparam logic [7:0] OFS_COUNT_HIGH_BYTE = 8'h08;
    localparam logic [7:0] OFS_FLAG_REG        = 8'h0c;
    localparam logic [7:0] OFS_ENABLE_REG      = 8'h10;
    localparam logic [7:0] OFS_PORT_C          = 8'h14;

    // ------------------------------------------------------------------
    // Control register fields and reset values
    // ------------------------------------------------------------------
    localparam int         BIT_WIDE_ACCESS   = 7;
    localparam int         BIT_PRESCALE_LO   = 4;
    localparam int         BIT_OSC_ENABLE    = 3;
    localparam int         BIT_SYNC_DISABLE  = 2;
    localparam int         BIT_CLOCK_SOURCE  = 1;
    localparam int         BIT_TIMER_RUN     = 0;
    localparam logic [7:0] CONTROL_WMASK     = 8'hbf;
    localparam logic [7:0] CONTROL_RESET     = 8'h00;
    localparam logic [1:0] DIRECTION_RESET   = 2'h3;
    localparam logic [1:0] LATCH_RESET       = 2'h0;

    // ------------------------------------------------------------------
    // Compare unit special event trigger mode
    // ------------------------------------------------------------------
    localparam logic [3:0] CMP_SPECIAL_EVENT = 4'hb;

endpackage

// file: rtl/clk_edge_if.sv
/*
 * Carrier between the timer core and its external clock edge detector.
 * Assumes both ends sit in the same core clock domain.
 */
`timescale 1ns/1ps
interface clk_edge_if;
    logic raw_clock;
    logic sync_bypass;
    logic rise;

    modport core (output raw_clock, output sync_bypass, input rise);
    modport det  (input raw_clock, input sync_bypass, output rise);
endinterface

// file: rtl/ext_edge_detect.sv
/*
 * Rising edge detector for the external timer clock, with an optional
 * two-stage synchroniser in front of it.
 * Assumes the raw clock level is a plain input sampled on clk.
 */
`timescale 1ns/1ps
module ext_edge_detect
    import timer16_pkg::*;
(
    // Clock and reset
    input  wire logic clk,
    input  wire logic reset,
    // Edge carrier
    clk_edge_if.det   ei
);

    typedef struct packed {
        logic stage_one;
        logic stage_two;
        logic prev_sync;
        logic prev_raw;
    } edge_state_t;

    edge_state_t st_ff;
    edge_state_t nxt_st;

    // ------------------------------------------------------------------
    // Synchroniser and history
    // ------------------------------------------------------------------
    // two-stage synchroniser
    always_comb begin
        nxt_st           = st_ff;
        nxt_st.stage_one = ei.raw_clock;
        nxt_st.stage_two = st_ff.stage_one;   // Only reader of stage_one
        nxt_st.prev_sync = st_ff.stage_two;
        nxt_st.prev_raw  = ei.raw_clock;
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // Unsynchronised path sees the pin directly, so it can race a clear
    // pick sync or raw edge
    assign ei.rise = ei.sync_bypass ? (ei.raw_clock & ~st_ff.prev_raw)
                                    : (st_ff.stage_two & ~st_ff.prev_sync);

endmodule

// file: rtl/timer16.sv
/*
 * 16-bit timer/counter with prescaler, external clock or low-power
 * oscillator source, overflow flag and compare-triggered clear, on APB.
 * Assumes APB master timing; pin inputs synchronous to clk.
 */
// Design decisions made here: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
module timer16
    import timer16_pkg::*;
(
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              reset,
    // APB slave
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [DATA_W-1:0] pwdata,
    output logic      [DATA_W-1:0] prdata,
    output logic                   pready,
    output logic                   pslverr,
    // Compare unit triggers
    input  wire logic              cmp_one_trigger,
    input  wire logic [3:0]        cmp_one_mode,
    input  wire logic              cmp_two_trigger,
    input  wire logic [3:0]        cmp_two_mode,
    // Core state
    input  wire logic              sleep,
    output logic                   overflow_irq,
    output logic                   osc_amp_enable,
    // Oscillator pins
    input  wire logic              osc_in_pin_in,
    output logic                   osc_in_pin_out,
    output logic                   osc_in_pin_oe,
    input  wire logic              osc_out_pin_in,
    output logic                   osc_out_pin_out,
    output logic                   osc_out_pin_oe
);

    typedef struct packed {
        logic [7:0]        timer_control;
        logic [15:0]       count;
        logic [7:0]        high_buffer;
        logic [2:0]        prescale;
        logic              overflow_flag;
        logic              overflow_irq_enable;
        logic [1:0]        port_c_direction;
        logic [1:0]        port_c_latch;
        logic [DATA_W-1:0] rdata;
    } timer_state_t;

    timer_state_t st_ff;
    timer_state_t nxt_st;
    clk_edge_if   ei ();

    logic       setup;
    logic       access;
    logic       mapped;
    logic       wr_ctrl;
    logic       wr_lo;
    logic       wr_hi;
    logic       wr_flag;
    logic       wr_ie;
    logic       wr_port;
    logic       cnt_write;
    logic       wide;
    logic       osc_en;
    logic       trig;
    logic       src_tick;
    logic       inc;
    logic       wrap;
    logic [2:0] ratio_m1;
    logic [1:0] pin_read;

    // ------------------------------------------------------------------
    // Control decode
    // ------------------------------------------------------------------
    // wide access mode
    assign wide   = st_ff.timer_control[BIT_WIDE_ACCESS];
    assign osc_en = st_ff.timer_control[BIT_OSC_ENABLE];

    // no sleep term, crystal keeps ticking
    assign osc_amp_enable = osc_en;

    // External clock comes from the shared pin, crystal or not
    assign ei.raw_clock   = osc_out_pin_in;
    assign ei.sync_bypass = st_ff.timer_control[BIT_SYNC_DISABLE];

    ext_edge_detect u_edge (
        .clk   (clk),
        .reset (reset),
        .ei    (ei)
    );

    // ------------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------------
    assign setup  = psel & ~penable;
    assign access = psel & penable;
    assign mapped = (paddr == OFS_TIMER_CONTROL)   || (paddr == OFS_COUNT_LOW_BYTE) ||
                    (paddr == OFS_COUNT_HIGH_BYTE) || (paddr == OFS_FLAG_REG) ||
                    (paddr == OFS_ENABLE_REG)      || (paddr == OFS_PORT_C);

    // Writes land only at the access edge
    assign wr_ctrl = access & pwrite & (paddr == OFS_TIMER_CONTROL);
    assign wr_lo   = access & pwrite & (paddr == OFS_COUNT_LOW_BYTE);
    assign wr_hi   = access & pwrite & (paddr == OFS_COUNT_HIGH_BYTE);
    assign wr_flag = access & pwrite & (paddr == OFS_FLAG_REG);
    assign wr_ie   = access & pwrite & (paddr == OFS_ENABLE_REG);
    assign wr_port = access & pwrite & (paddr == OFS_PORT_C);

    // High write in wide mode only fills the buffer
    assign cnt_write = wr_lo | (wr_hi & ~wide);

    // Zero wait states; unmapped words answer with an error
    assign pready  = 1'b1;
    assign pslverr = access & ~mapped;
    assign prdata  = st_ff.rdata;

    // ------------------------------------------------------------------
    // Count source and prescaler
    // ------------------------------------------------------------------
    // internal tick each cycle, core clock halts in Sleep
    assign src_tick = st_ff.timer_control[BIT_CLOCK_SOURCE] ? ei.rise : ~sleep;

    always_comb begin
        case (st_ff.timer_control[BIT_PRESCALE_LO +: 2])
            2'h0:    ratio_m1 = 3'h0;
            2'h1:    ratio_m1 = 3'h1;
            2'h2:    ratio_m1 = 3'h3;
            2'h3:    ratio_m1 = 3'h7;
            default: ratio_m1 = 3'h0;
        endcase
    end

    // only counts while running
    // Greater-or-equal so a ratio cut mid-count cannot stall for up to 7 ticks
    assign inc  = st_ff.timer_control[BIT_TIMER_RUN] & src_tick & (st_ff.prescale >= ratio_m1);
    assign wrap = inc & (st_ff.count == 16'hffff);

    // unsynchronised edges may land beside it; no extra guarding
    assign trig = (cmp_one_trigger & (cmp_one_mode == CMP_SPECIAL_EVENT)) |
                  (cmp_two_trigger & (cmp_two_mode == CMP_SPECIAL_EVENT));

    // ------------------------------------------------------------------
    // Pins
    // ------------------------------------------------------------------
    // oscillator overrides direction, pins read zero
    assign pin_read        = osc_en ? 2'h0 : {osc_in_pin_in, osc_out_pin_in};
    assign osc_out_pin_oe  = ~osc_en & ~st_ff.port_c_direction[0];
    assign osc_in_pin_oe   = ~osc_en & ~st_ff.port_c_direction[1];
    assign osc_out_pin_out = st_ff.port_c_latch[0];
    assign osc_in_pin_out  = st_ff.port_c_latch[1];

    assign overflow_irq = st_ff.overflow_flag & st_ff.overflow_irq_enable;

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        nxt_st = st_ff;

        // Control and plain registers
        if (wr_ctrl) begin
            nxt_st.timer_control = pwdata[7:0] & CONTROL_WMASK;
        end
        if (wr_ie) begin
            nxt_st.overflow_irq_enable = pwdata[0];
        end
        if (wr_port) begin
            nxt_st.port_c_direction = pwdata[1:0];
            nxt_st.port_c_latch     = pwdata[3:2];
        end

        // Prescaler
        if (st_ff.timer_control[BIT_TIMER_RUN] & src_tick) begin
            nxt_st.prescale = (st_ff.prescale >= ratio_m1) ? 3'h0 : st_ff.prescale + 3'h1;
        end
        if (wr_lo) begin
            nxt_st.prescale = 3'h0;
        end

        // Counter: write, then trigger clear, then increment
        if (wr_lo) begin
            nxt_st.count = {(wide ? st_ff.high_buffer : st_ff.count[15:8]), pwdata[7:0]};
        end else if (wr_hi & ~wide) begin
            // byte mode hits live high byte
            nxt_st.count[15:8] = pwdata[7:0];
        end else if (trig) begin
            // restart from zero makes compare value the period
            nxt_st.count = 16'h0000;
        end else if (inc) begin
            nxt_st.count = st_ff.count + 16'h0001;
        end

        // wide high write fills buffer only
        if (wr_hi & wide) begin
            nxt_st.high_buffer = pwdata[7:0];
        end
        if (setup & ~pwrite & wide & (paddr == OFS_COUNT_LOW_BYTE)) begin
            nxt_st.high_buffer = st_ff.count[15:8];
        end

        // Flag: software write, then hardware set wins
        if (wr_flag) begin
            nxt_st.overflow_flag = pwdata[0];
        end
        // only a real wrap sets it, a count write (low byte, or high byte in byte mode) or trigger cancels the wrap
        if (wrap & ~cnt_write & ~trig) begin
            nxt_st.overflow_flag = 1'b1;
        end

        // Read data captured in setup so the low byte and buffer agree
        if (setup & ~pwrite) begin
            case (paddr)
                OFS_TIMER_CONTROL:   nxt_st.rdata = {24'h0, st_ff.timer_control};
                OFS_COUNT_LOW_BYTE:  nxt_st.rdata = {24'h0, st_ff.count[7:0]};
                OFS_COUNT_HIGH_BYTE: nxt_st.rdata = {24'h0, (wide ? st_ff.high_buffer : st_ff.count[15:8])};
                OFS_FLAG_REG:        nxt_st.rdata = {31'h0, st_ff.overflow_flag};
                OFS_ENABLE_REG:      nxt_st.rdata = {31'h0, st_ff.overflow_irq_enable};
                OFS_PORT_C:          nxt_st.rdata = {26'h0, pin_read, st_ff.port_c_latch, st_ff.port_c_direction};
                default:             nxt_st.rdata = 32'h0;
            endcase
        end
    end

    // State register
    always_ff @(posedge clk) begin
        if (reset) begin
            st_ff                  <= '0;
            st_ff.timer_control    <= CONTROL_RESET;
            st_ff.port_c_direction <= DIRECTION_RESET;
            st_ff.port_c_latch     <= LATCH_RESET;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    chk_wrap_sets_flag: assert property (
        wrap & ~cnt_write & ~trig |=> (st_ff.count == 16'h0000) && st_ff.overflow_flag)
        else $error("wrap did not zero count and set flag");

    chk_trigger_clears: assert property (
        trig & ~cnt_write |=> st_ff.count == 16'h0000)
        else $error("trigger did not clear count");

    chk_trigger_no_flag: assert property (
        trig & ~cnt_write & ~wr_flag & ~st_ff.overflow_flag |=> ~st_ff.overflow_flag)
        else $error("trigger clear set overflow flag");

    chk_write_beats_trig: assert property (
        wr_lo & trig |=> st_ff.count[7:0] == $past(pwdata[7:0]))
        else $error("trigger overrode counter write");

    chk_stopped_holds: assert property (
        ~st_ff.timer_control[BIT_TIMER_RUN] & ~cnt_write & ~trig |=> $stable(st_ff.count))
        else $error("stopped counter changed");

    chk_internal_rate: assert property (
        st_ff.timer_control[1:0] == 2'h1 && st_ff.timer_control[5:4] == 2'h0 && !sleep
        && !cnt_write && !trig |=> st_ff.count == $past(st_ff.count) + 16'h0001)
        else $error("internal clock did not count each cycle");

    chk_irq_gated: assert property (
        overflow_irq |-> st_ff.overflow_irq_enable && st_ff.overflow_flag)
        else $error("interrupt without enable");

    chk_osc_pins_input: assert property (
        osc_en |-> !osc_in_pin_oe && !osc_out_pin_oe)
        else $error("oscillator pin driven while oscillator on");

    chk_buffer_snapshot: assert property (
        setup & ~pwrite & wide & (paddr == OFS_COUNT_LOW_BYTE)
        |=> st_ff.high_buffer == $past(st_ff.count[15:8]))
        else $error("high buffer missed snapshot");

    chk_prescale_cleared: assert property (
        wr_lo |=> st_ff.prescale == 3'h0)
        else $error("low write left prescaler running");

    cov_wrap:       cover property (wrap);
    cov_trig_clear: cover property (trig ##1 st_ff.count == 16'h0000);
    cov_ext_count:  cover property (st_ff.timer_control[BIT_CLOCK_SOURCE] && inc);
    cov_wide_write: cover property (wr_hi & wide ##[1:8] wr_lo);

endmodule

// file: verification/ext_clock_source.sv
/*
 * Behavioural external count clock for the timer: a pin driver or crystal.
 * Assumes the bench calls send() from its main process; the clock idles low.
 */
`timescale 1ns/1ps
module ext_clock_source (
    // Core clock
    input  wire logic clk,
    // Count clock pin
    output logic      ext_clk
);
    // Idle low outside bursts, so no stray edge reaches the counter
    initial ext_clk = 1'b0;

    // rising edges, slow enough for the synchroniser
    task automatic send(input int n);
        int w;
        repeat (n) begin
            // Random phase lengths between prompt and slow
            w = 3 + ($urandom % 4);
            @(posedge clk);
            ext_clk <= 1'b1;
            repeat (w) @(posedge clk);
            ext_clk <= 1'b0;
            repeat (w) @(posedge clk);
        end
    endtask
endmodule

// file: verification/tb_timer16.sv
/*
 * Self-checking bench for the 16-bit timer: APB master, count checks.
 * Assumes the design answers with pready; the far side is ext_clock_source.
 */
`timescale 1ns/1ps
module tb_timer16
    import timer16_pkg::*;
;
    // ------------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------------
    logic              clk = 1'b0;
    logic              reset = 1'b1;
    logic              psel = 1'b0;
    logic              penable = 1'b0;
    logic              pwrite = 1'b0;
    logic [ADDR_W-1:0] paddr = '0;
    logic [DATA_W-1:0] pwdata = '0;
    logic [DATA_W-1:0] prdata;
    logic              pready;
    logic              pslverr;
    logic              cmp_one_trigger = 1'b0;
    logic [3:0]        cmp_one_mode = 4'h0;
    logic              cmp_two_trigger = 1'b0;
    logic [3:0]        cmp_two_mode = 4'h0;
    logic              sleep = 1'b1;
    logic              overflow_irq;
    logic              osc_amp_enable;
    logic              osc_in_pin_in;
    logic              osc_in_pin_out;
    logic              osc_in_pin_oe;
    logic              osc_out_pin_in;
    logic              osc_out_pin_out;
    logic              osc_out_pin_oe;
    logic              ext_clk;
    logic              osc_in_drv = 1'b0;
    logic [31:0]       q;
    logic              serr;
    int                err_total = 0;
    int                checks = 0;
    int                mc;
    int                v;

    // Pin levels follow whoever drives them
    assign osc_in_pin_in  = osc_in_pin_oe ? osc_in_pin_out : osc_in_drv;
    assign osc_out_pin_in = osc_out_pin_oe ? osc_out_pin_out : ext_clk;

    always #50 clk = ~clk;

    timer16 timer16_i (.clk(clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .cmp_one_trigger(cmp_one_trigger), .cmp_one_mode(cmp_one_mode),
        .cmp_two_trigger(cmp_two_trigger), .cmp_two_mode(cmp_two_mode), .sleep(sleep),
        .overflow_irq(overflow_irq), .osc_amp_enable(osc_amp_enable),
        .osc_in_pin_in(osc_in_pin_in), .osc_in_pin_out(osc_in_pin_out), .osc_in_pin_oe(osc_in_pin_oe),
        .osc_out_pin_in(osc_out_pin_in), .osc_out_pin_out(osc_out_pin_out),
        .osc_out_pin_oe(osc_out_pin_oe));
    ext_clock_source ext_clock_source_i (.clk(clk), .ext_clk(ext_clk));

    // ------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            err_total++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // One APB transfer; trg raises the unit one trigger on the access edge
    task automatic apb(input bit wr, input logic [7:0] a, input logic [31:0] d, input bit trg = 0);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        cmp_one_trigger <= trg;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        q = prdata;
        serr = pslverr;
        if (pready !== 1'b1) chk("pready", 32'h0, 32'h1);
        psel <= 1'b0;
        penable <= 1'b0;
        cmp_one_trigger <= 1'b0;
    endtask

    // Byte order keeps the wide buffer and byte mode alike
    task automatic set_count(input int c);
        apb(1, OFS_COUNT_HIGH_BYTE, (c >> 8) & 8'hff);
        apb(1, OFS_COUNT_LOW_BYTE, c & 8'hff);
    endtask

    task automatic rd_count(output int c);
        apb(0, OFS_COUNT_LOW_BYTE, 0);
        c = q & 8'hff;
        apb(0, OFS_COUNT_HIGH_BYTE, 0);
        c = c | ((q & 8'hff) << 8);
    endtask

    task automatic results;
        $display("checks %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // Watchdog far beyond the few thousand cycles the tests need
    initial begin
        repeat (60000) @(posedge clk);
        err_total++;
        results;
    end

    // ------------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------------
    initial begin
        void'($urandom(32'hc4ce));
        osc_in_drv <= 1'($urandom % 2);
        repeat (5) @(posedge clk);
        reset <= 1'b0;
        apb(0, OFS_TIMER_CONTROL, 0);
        chk("ctrl reset", q, 32'h0);
        apb(0, OFS_PORT_C, 0);
        chk("port reset", q, 32'h3 | (32'(osc_in_drv) << 5));
        apb(1, OFS_TIMER_CONTROL, 32'hff);
        apb(0, OFS_TIMER_CONTROL, 0);
        chk("ctrl bits", q, 32'hbf);
        apb(1, 8'h40, 32'h5);
        chk("unmapped err", 32'(serr), 32'h1);
        apb(0, 8'h40, 0);
        chk("unmapped read", q, 32'h0);
        $display("test registers done");
        // Internal clock: exactly 24 awake cycles, divided by the prescale
        for (int p = 0; p < 4; p++) begin
            apb(1, OFS_TIMER_CONTROL, (p << 4) | 1);
            set_count(0);
            @(posedge clk);
            sleep <= 1'b0;
            repeat (24) @(posedge clk);
            sleep <= 1'b1;
            rd_count(v);
            chk("internal count", v, 24 >> p);
        end
        $display("test internal done");
        // External edges, counted while the core sleeps
        mc = 100;
        for (int i = 0; i < 8; i++) begin
            apb(1, OFS_TIMER_CONTROL, ((i % 4) << 4) | ((i % 2) << 3) | ((i / 4) << 2) | 3);
            set_count(mc);
            ext_clock_source_i.send(16);
            repeat (6) @(posedge clk);
            apb(1, OFS_TIMER_CONTROL, 2);
            mc = mc + (16 >> (i % 4));
            rd_count(v);
            chk("external count", v, mc);
        end
        ext_clock_source_i.send(5);
        repeat (6) @(posedge clk);
        rd_count(v);
        chk("stopped count", v, mc);
        $display("test external done");
        // Wide access buffer against byte access
        apb(1, OFS_TIMER_CONTROL, 0);
        set_count(16'h1234);
        apb(1, OFS_TIMER_CONTROL, 32'h80);
        apb(0, OFS_COUNT_LOW_BYTE, 0);
        chk("wide low", q, 32'h34);
        apb(0, OFS_COUNT_HIGH_BYTE, 0);
        chk("snapshot high", q, 32'h12);
        apb(1, OFS_COUNT_HIGH_BYTE, 32'h56);
        apb(0, OFS_COUNT_HIGH_BYTE, 0);
        chk("buffer high", q, 32'h56);
        apb(1, OFS_COUNT_LOW_BYTE, 32'h78);
        apb(1, OFS_TIMER_CONTROL, 0);
        rd_count(v);
        chk("wide write", v, 32'h5678);
        apb(1, OFS_COUNT_HIGH_BYTE, 32'h9a);
        apb(0, OFS_COUNT_HIGH_BYTE, 0);
        chk("live high", q, 32'h9a);
        $display("test wide done");
        // Rollover sets the flag; the enable gates the request
        apb(1, OFS_TIMER_CONTROL, 32'h80);
        set_count(16'hfffe);
        apb(1, OFS_TIMER_CONTROL, 32'h87);
        ext_clock_source_i.send(2);
        repeat (6) @(posedge clk);
        apb(1, OFS_TIMER_CONTROL, 32'h80);
        rd_count(v);
        chk("wrap count", v, 0);
        apb(0, OFS_FLAG_REG, 0);
        chk("overflow flag", q, 32'h1);
        chk("irq masked", 32'(overflow_irq), 32'h0);
        apb(1, OFS_ENABLE_REG, 1);
        @(negedge clk);
        chk("irq enabled", 32'(overflow_irq), 32'h1);
        apb(1, OFS_FLAG_REG, 0);
        @(negedge clk);
        chk("irq cleared", 32'(overflow_irq), 32'h0);
        $display("test overflow done");
        // Compare triggers from either unit, right and wrong mode
        apb(1, OFS_TIMER_CONTROL, 0);
        for (int u = 0; u < 2; u++) begin
            for (int k = 0; k < 2; k++) begin
                set_count(16'h00a5);
                cmp_one_mode <= k ? CMP_SPECIAL_EVENT : 4'($urandom % 11);
                cmp_two_mode <= k ? CMP_SPECIAL_EVENT : 4'($urandom % 11);
                @(posedge clk);
                cmp_one_trigger <= (u == 0);
                cmp_two_trigger <= (u == 1);
                @(posedge clk);
                cmp_one_trigger <= 1'b0;
                cmp_two_trigger <= 1'b0;
                rd_count(v);
                chk("trigger clear", v, k ? 0 : 16'h00a5);
                apb(0, OFS_FLAG_REG, 0);
                chk("no trigger flag", q, 32'h0);
            end
        end
        apb(1, OFS_COUNT_LOW_BYTE, 32'h5a, 1);
        rd_count(v);
        chk("write beats trigger", v, 16'h005a);
        $display("test trigger done");
        // Oscillator enable takes the pins over as inputs
        apb(1, OFS_PORT_C, 32'h08);
        @(negedge clk);
        chk("pins driven", {osc_in_pin_oe, osc_out_pin_oe, osc_in_pin_out, osc_out_pin_out}, 4'he);
        apb(0, OFS_PORT_C, 0);
        chk("pin read", q, 32'h28);
        apb(1, OFS_TIMER_CONTROL, 32'h08);
        @(negedge clk);
        chk("osc amp", 32'(osc_amp_enable), 32'h1);
        chk("pins released", {osc_in_pin_oe, osc_out_pin_oe}, 2'b00);
        apb(0, OFS_PORT_C, 0);
        chk("pins read zero", q, 32'h08);
        apb(1, OFS_TIMER_CONTROL, 0);
        @(negedge clk);
        chk("osc off", 32'(osc_amp_enable), 32'h0);
        $display("test pins done");
        results;
    end
endmodule
